/* flash_status_pkg.sv */
package flash_status_pkg;

  // clock and bus timing, in ns as the part needs them
  localparam int CLK_PERIOD_NS = 25;
  localparam int T_READ_NS     = 90;  // read access time, least
  localparam int T_WE_NS       = 35;  // write strobe low time, least
  localparam int RD_CYC = (T_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
                          (T_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WE_CYC = (T_WE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
                          (T_WE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // flash bus widths
  localparam int ADDR_W = 20;
  localparam int DATA_W = 8;

  // status bit positions on the data bus
  localparam int POLL_STATUS_BIT  = 7;
  localparam int TOGGLE_BIT_ONE   = 6;
  localparam int TIMEOUT_FAIL_BIT = 5;
  localparam int ERASE_WINDOW_BIT = 3;
  localparam int TOGGLE_BIT_TWO   = 2;

  localparam logic [DATA_W-1:0] CMD_RESET = 8'hf0;

  // register word indices on the avalon slave
  localparam logic [2:0] REG_CTRL   = 3'h0;
  localparam logic [2:0] REG_ADDR   = 3'h1;
  localparam logic [2:0] REG_WDATA  = 3'h2;
  localparam logic [2:0] REG_STATUS = 3'h3;
  localparam logic [2:0] REG_RDATA  = 3'h4;

  // control register fields
  localparam int CTRL_START  = 0;
  localparam int CTRL_OP_LSB = 1;

  // status register fields
  localparam int ST_BUSY = 0;
  localparam int ST_PASS = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_RDY  = 3;
  localparam int ST_TB2  = 4;
  localparam int ST_EWIN = 5;

  localparam logic [31:0] RESET_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    OP_WRITE  = 2'h0,
    OP_READ   = 2'h1,
    OP_POLL   = 2'h2,
    OP_TOGGLE = 2'h3
  } op_t;

  typedef enum logic [3:0] {
    S_IDLE  = 4'b0001,
    S_READ  = 4'b0010,
    S_WRITE = 4'b0100,
    S_EVAL  = 4'b1000
  } state_t;

  typedef enum logic [1:0] {
    ACT_READ  = 2'h0,
    ACT_RESET = 2'h1,
    ACT_PASS  = 2'h2,
    ACT_FAIL  = 2'h3
  } act_t;

  // pins driven toward the flash
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
    logic              dq_oe;
    logic              ce_n;
    logic              oe_n;
    logic              we_n;
  } flash_out_t;

endpackage

/* flash_status_host.sv */
// Function
// - host reads polling status at the programmed address
// - host reads erase status inside a sector chosen for erasure
// - after polling bit turns true, host takes data from the next read
// - timeout-failure bit seen: host reads the polling bit once more
// - host does two back-to-back reads and compares toggle bits
// - still toggling with failure bit high: host fails and sends reset command
// - host restarts toggle check from its first double read on resuming
`timescale 1ns/1ps
module flash_status_host
  import flash_status_pkg::*;
(
  input  wire logic              clk_sys,          // system clock, 40 MHz
  input  wire logic              rst,              // async reset, active high
  input  wire logic [2:0]        avs_address,      // register word index
  input  wire logic              avs_read,         // avalon read
  input  wire logic              avs_write,        // avalon write
  input  wire logic [31:0]       avs_writedata,    // avalon write data
  output logic      [31:0]       avs_readdata,     // avalon read data
  output logic                   avs_waitrequest,  // avalon stall
  output flash_out_t             flash_o,          // pins toward the flash
  input  wire logic [DATA_W-1:0] dq_in,            // flash data bus level
  input  wire logic              ready_busy_out    // flash ready/busy, high = ready
);

  state_t            state;
  op_t               op;
  logic [2:0]        step;
  logic [3:0]        cnt;
  logic [DATA_W-1:0] sample;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic              t1_first;
  logic              t2_first;
  logic              pass;
  logic              fail;
  logic              tb2_seen;
  logic              rd_ack;
  logic [3:0]        rd_count;
  logic              recheck_seen;

  // register decode
  wire wr_ctrl  = avs_write && avs_address == REG_CTRL;
  wire wr_addr  = avs_write && avs_address == REG_ADDR;
  wire wr_wdata = avs_write && avs_address == REG_WDATA;
  wire busy     = state != S_IDLE;
  wire start    = wr_ctrl && avs_writedata[CTRL_START] && !busy;  // starts while busy are dropped
  wire op_t start_op = op_t'(avs_writedata[CTRL_OP_LSB +: 2]);

  // status bits of the current sample
  wire poll_true = sample[POLL_STATUS_BIT] == wdata_reg[POLL_STATUS_BIT];
  wire tb1_same  = sample[TOGGLE_BIT_ONE] == t1_first;
  wire tb2_diff  = sample[TOGGLE_BIT_TWO] != t2_first;
  wire fail_bit  = sample[TIMEOUT_FAIL_BIT];

  // reads stall one cycle so read data come from a flop
  assign avs_waitrequest = avs_read && !rd_ack;

  wire [31:0] status_word = {26'h0, sample[ERASE_WINDOW_BIT], tb2_seen, ready_busy_out, fail, pass, busy};
  wire [31:0] rd_mux = avs_address == REG_CTRL   ? {29'h0, op, 1'b0} :
                       avs_address == REG_ADDR   ? {12'h0, addr_reg} :
                       avs_address == REG_WDATA  ? {24'h0, wdata_reg} :
                       avs_address == REG_STATUS ? status_word :
                       avs_address == REG_RDATA  ? {24'h0, sample} : RESET_ZERO;

  // algorithm decision after each finished cycle
  act_t       next_act;
  logic [2:0] next_step;
  always_comb begin
    next_act  = ACT_PASS;
    next_step = 3'd0;
    case (op)
      OP_POLL: begin
        case (step)
          3'd0: begin
            next_act = ACT_READ;
            if (poll_true) begin
              next_step = 3'd2;                 // one more read for valid data
            end else if (fail_bit) begin
              next_step = 3'd1;                 // failure bit may move with poll bit
            end else begin
              next_step = 3'd0;
            end
          end
          3'd1: begin
            next_act  = poll_true ? ACT_READ : ACT_RESET;
            next_step = poll_true ? 3'd2 : 3'd3;
          end
          3'd3:    next_act = ACT_FAIL;
          default: next_act = ACT_PASS;
        endcase
      end
      OP_TOGGLE: begin
        case (step)
          3'd0: begin
            next_act  = ACT_READ;
            next_step = 3'd1;
          end
          3'd4: begin
            next_act  = ACT_READ;
            next_step = 3'd5;
          end
          3'd1: begin
            next_act = ACT_READ;
            if (tb1_same) begin
              next_step = 3'd2;                 // stopped: next read is array data
            end else if (fail_bit) begin
              next_step = 3'd4;                 // recheck with a fresh pair
            end else begin
              next_step = 3'd0;                 // still busy: begin again with a pair
            end
          end
          3'd5: begin
            next_act  = tb1_same ? ACT_READ : ACT_RESET;
            next_step = tb1_same ? 3'd2 : 3'd3;
          end
          3'd3:    next_act = ACT_FAIL;
          default: next_act = ACT_PASS;
        endcase
      end
      default: next_act = ACT_PASS;
    endcase
  end

  // avalon register writes and read data
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      addr_reg     <= '0;
      wdata_reg    <= '0;
      rd_ack       <= 1'b0;
      avs_readdata <= RESET_ZERO;
    end else begin
      rd_ack <= avs_read && !rd_ack;
      if (avs_read && !rd_ack) begin
        avs_readdata <= rd_mux;
      end
      if (wr_addr && !busy) begin
        addr_reg <= avs_writedata[ADDR_W-1:0];
      end
      if (wr_wdata && !busy) begin
        wdata_reg <= avs_writedata[DATA_W-1:0];
      end
    end
  end

  // bus cycle engine and sequencer; the address stays fixed for the whole
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state   <= S_IDLE;
      op      <= OP_WRITE;
      step    <= 3'd0;
      cnt     <= 4'd0;
      sample  <= '0;
      flash_o <= '{addr: '0, dq_out: '0, dq_oe: 1'b0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
    end else begin
      case (state)
        S_IDLE: begin
          if (start) begin
            op              <= start_op;
            step            <= 3'd0;
            cnt             <= 4'd0;
            flash_o.addr    <= addr_reg;
            flash_o.dq_out  <= wdata_reg;
            flash_o.ce_n    <= 1'b0;
            flash_o.dq_oe   <= start_op == OP_WRITE;
            flash_o.we_n    <= start_op != OP_WRITE;
            flash_o.oe_n    <= start_op == OP_WRITE;
            state           <= start_op == OP_WRITE ? S_WRITE : S_READ;
          end
        end
        S_READ: begin
          cnt <= cnt + 4'd1;
          if (cnt == 4'(RD_CYC - 1)) begin
            sample       <= dq_in;
            flash_o.ce_n <= 1'b1;
            flash_o.oe_n <= 1'b1;
            state        <= S_EVAL;
          end
        end
        S_WRITE: begin
          cnt <= cnt + 4'd1;
          if (cnt == 4'(WE_CYC - 1)) begin
            flash_o.ce_n <= 1'b1;
            flash_o.we_n <= 1'b1;
            state        <= S_EVAL;
          end
        end
        S_EVAL: begin
          flash_o.dq_oe <= 1'b0;              // data held one cycle past the strobe
          cnt           <= 4'd0;
          step          <= next_step;
          case (next_act)
            ACT_READ: begin
              flash_o.ce_n <= 1'b0;
              flash_o.oe_n <= 1'b0;
              state        <= S_READ;
            end
            ACT_RESET: begin
              flash_o.dq_out <= CMD_RESET;    // failed: back to array reads
              flash_o.dq_oe  <= 1'b1;
              flash_o.ce_n   <= 1'b0;
              flash_o.we_n   <= 1'b0;
              state          <= S_WRITE;
            end
            default: state <= S_IDLE;
          endcase
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // outcome flags and toggle history; flags and tb2_seen cleared by a new start, t1_first/t2_first reloaded at each first read
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pass         <= 1'b0;
      fail         <= 1'b0;
      t1_first     <= 1'b0;
      t2_first     <= 1'b0;
      tb2_seen     <= 1'b0;
      rd_count     <= 4'd0;
      recheck_seen <= 1'b0;
    end else begin
      if (start) begin
        pass         <= 1'b0;
        fail         <= 1'b0;
        tb2_seen     <= 1'b0;
        rd_count     <= 4'd0;
        recheck_seen <= 1'b0;
      end
      if (state == S_READ && cnt == 4'(RD_CYC - 1) && rd_count != 4'hf) begin
        rd_count <= rd_count + 4'd1;
      end
      if (state == S_EVAL) begin
        if (op == OP_TOGGLE && (step == 3'd0 || step == 3'd4)) begin
          t1_first <= sample[TOGGLE_BIT_ONE];
          t2_first <= sample[TOGGLE_BIT_TWO];
        end
        if (op == OP_TOGGLE && (step == 3'd1 || step == 3'd5) && tb2_diff) begin
          tb2_seen <= 1'b1;                   // address lies in a sector chosen for erasure
        end
        if ((op == OP_POLL && step == 3'd1) || (op == OP_TOGGLE && step == 3'd5)) begin
          recheck_seen <= 1'b1;
        end
        pass <= pass | (next_act == ACT_PASS);
        fail <= fail | (next_act == ACT_FAIL);
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_poll_addr_fixed: assert property (state == S_READ |-> flash_o.addr == addr_reg)
    else $error("status read not at the requested address");
  chk_addr_stable_busy: assert property (busy && $past(busy) |-> $stable(flash_o.addr))
    else $error("flash address moved during a status check");
  chk_poll_extra_read: assert property ($rose(pass) && op == OP_POLL |-> rd_count >= 4'd2)
    else $error("polling passed without a following data read");
  chk_poll_recheck: assert property ($rose(fail) && op == OP_POLL |-> recheck_seen)
    else $error("polling failed without a second look at the poll bit");
  chk_toggle_pair: assert property ($rose(pass) && op == OP_TOGGLE |-> rd_count >= 4'd3)
    else $error("toggle check passed without a pair and a data read");
  chk_fail_reset_cmd: assert property ($rose(fail) |-> $past(flash_o.dq_out, 2) == CMD_RESET && recheck_seen)
    else $error("failure reported without a reset command");
  chk_toggle_restart: assert property (state == S_EVAL && op == OP_TOGGLE && step == 3'd1 && !tb1_same && !fail_bit
                                       |=> state == S_READ && step == 3'd0 ##[1:16] state == S_EVAL)
    else $error("toggle check did not restart with a fresh read pair");

endmodule

/* flash_dev_model.sv */
`timescale 1ns/1ps
// behavioural flash status responder; one array byte stands for the whole part
module flash_dev_model
  import flash_status_pkg::*;
(
  input  wire logic              clk_sys,        // bench clock, to see strobe edges and to load a new mode on go
  input  wire logic              rst,            // async reset, active high
  input  wire flash_out_t        pins,           // strobes, address and data from the host
  input  wire logic              go,             // load a new mode
  input  wire logic [2:0]        mode_in,        // 0 array 1 prog 2 erase 3 stuck 4 suspend 5 protected
  input  wire logic [7:0]        len_in,         // busy reads before the operation ends
  input  wire logic [7:0]        data_in,        // datum being programmed
  output logic      [DATA_W-1:0] dq,             // data bus from the device
  output logic                   ready_busy_out, // open drain with pull-up, high = ready
  output logic      [3:0]        resets          // reset commands seen
);
  logic [2:0] mode;
  logic [7:0] cnt;
  logic [7:0] arr;
  logic [7:0] pd;
  logic [7:0] val;
  logic [7:0] last;
  logic       t1;
  logic       t2;
  logic       rsel_q;
  logic       wsel_q;
  wire        rsel = !pins.ce_n && !pins.oe_n;
  wire        wsel = !pins.ce_n && !pins.we_n;
  wire        busy = mode inside {3'd1, 3'd2, 3'd3, 3'd5};

  // status byte while an operation is pending, array data otherwise
  always_comb begin
    case (mode)
      3'd1, 3'd3, 3'd5: val = {~pd[7], t1, mode == 3'd3, arr[4:0]};
      3'd2:             val = {1'b0, t1, 2'b00, 1'b1, t2, 2'b00};
      3'd4:             val = {1'b1, t1, 3'b000, t2, 2'b00};
      default:          val = arr;
    endcase
  end

  // a released bus shows the inverse of its last level, so stale data never passes
  assign dq             = rsel ? val : ~last;
  assign ready_busy_out = !busy;

  // strobe edges are seen one clock late; the host holds them for several cycles
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode   <= 3'd0;
      cnt    <= 8'h00;
      arr    <= 8'h3c;
      pd     <= 8'h00;
      last   <= 8'h00;
      t1     <= 1'b0;
      t2     <= 1'b0;
      rsel_q <= 1'b0;
      wsel_q <= 1'b0;
      resets <= 4'h0;
    end else begin
      rsel_q <= rsel;
      wsel_q <= wsel;
      if (go) begin
        mode <= mode_in;
        cnt  <= len_in;
        pd   <= data_in;
      end
      if (rsel && !rsel_q && mode != 3'd0) begin
        t1 <= (mode == 3'd4) ? t1 : ~t1;
        t2 <= ~t2;
        if (mode inside {3'd1, 3'd2, 3'd5}) begin
          if (cnt == 8'h00) begin
            mode <= 3'd0;
            if (mode == 3'd1)
              arr <= pd;
            if (mode == 3'd2)
              arr <= 8'hff;
          end else
            cnt <= cnt - 8'h01;
        end
      end
      if (rsel_q && !rsel)
        last <= val;
      if (wsel_q && !wsel) begin
        if (pins.dq_out == CMD_RESET) begin
          mode   <= 3'd0;
          resets <= resets + 4'h1;
        end else if (mode == 3'd0)
          arr <= pins.dq_out;
      end
    end
  end
endmodule

/* tb_flash_status_host.sv */
`timescale 1ns/1ps
module tb_flash_status_host
  import flash_status_pkg::*;
;
  logic        clk_sys;
  logic        rst           = 1'b1;
  logic [2:0]  avs_address   = 3'h0;
  logic        avs_read      = 1'b0;
  logic        avs_write     = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  flash_out_t  flash_o;
  logic [7:0]  dq_dev;
  logic        ready_busy_out;
  logic        go            = 1'b0;
  logic [2:0]  mode_in       = 3'h0;
  logic [7:0]  len_in        = 8'h0;
  logic [7:0]  data_in       = 8'h0;
  logic [3:0]  resets;
  logic [31:0] rd;
  int          fails         = 0;
  int          checks_done   = 0;
  int          cycles        = 0;
  wire  [7:0]  dq_in         = flash_o.dq_oe ? flash_o.dq_out : dq_dev; // host drive wins while enabled

  // rows: prog poll, erase poll, erase toggle, suspend, protected prog, stuck toggle, stuck poll
  logic [2:0] t_mode  [7] = '{3'd1, 3'd2, 3'd2, 3'd4, 3'd5, 3'd3, 3'd3};
  logic [7:0] t_len   [7] = '{8'h05, 8'h06, 8'h06, 8'h00, 8'h04, 8'h00, 8'h00};
  logic [7:0] t_data  [7] = '{8'ha5, 8'h80, 8'h80, 8'h80, 8'h00, 8'h00, 8'h80};
  logic [1:0] t_op    [7] = '{2'h2, 2'h2, 2'h3, 2'h3, 2'h3, 2'h3, 2'h2};
  logic [7:0] t_sexp  [7] = '{8'h0a, 8'h0a, 8'h3a, 8'h1a, 8'h0a, 8'h0c, 8'h0c};
  logic [7:0] t_smask [7] = '{8'h0f, 8'h0f, 8'h3f, 8'h1f, 8'h1f, 8'h1f, 8'h0f};
  logic [7:0] t_rexp  [7] = '{8'ha5, 8'hff, 8'hff, 8'h80, 8'hff, 8'h00, 8'h00};
  logic [7:0] t_rmask [7] = '{8'hff, 8'hff, 8'hff, 8'h80, 8'hff, 8'h00, 8'h00};

  flash_status_host dut_u (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .flash_o(flash_o), .dq_in(dq_in), .ready_busy_out(ready_busy_out));
  flash_dev_model dev_u (.clk_sys(clk_sys), .rst(rst), .pins(flash_o), .go(go), .mode_in(mode_in),
    .len_in(len_in), .data_in(data_in), .dq(dq_dev), .ready_busy_out(ready_busy_out), .resets(resets));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic report_and_stop;
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // a request holds until waitrequest is seen low; one idle edge follows before the next
  task automatic bus_wr(input logic [2:0] a, input logic [31:0] d);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= 1'b1;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic bus_rd(input logic [2:0] a, output logic [31:0] d);
    avs_address <= a;
    avs_read    <= 1'b1;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic start_op(input logic [1:0] op, input logic [7:0] wd);
    bus_wr(REG_ADDR, 32'h0001_2345);
    bus_wr(REG_WDATA, {24'h0, wd});
    bus_wr(REG_CTRL, {29'h0, op, 1'b1});
  endtask

  task automatic wait_done;
    rd = 32'h1;
    while (rd[ST_BUSY] !== 1'b0)
      bus_rd(REG_STATUS, rd);
  endtask

  // hang guard, far above the few hundred cycles the sequence needs
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      report_and_stop;
    end
  end

  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    bus_rd(REG_STATUS, rd);
    check(rd, 32'h8);
    bus_rd(REG_CTRL, rd);
    check(rd, 32'h0);
    bus_rd(3'h7, rd);
    check(rd, 32'h0);
    start_op(OP_WRITE, 8'h5a);
    wait_done;
    start_op(OP_READ, 8'h00);
    wait_done;
    bus_rd(REG_RDATA, rd);
    check(rd, 32'h5a);
    bus_rd(REG_CTRL, rd);
    check(rd, 32'h2);
    for (int i = 0; i < 7; i++) begin
      mode_in <= t_mode[i];
      len_in  <= t_len[i];
      data_in <= t_data[i];
      go      <= 1'b1;
      @(posedge clk_sys);
      go <= 1'b0;
      start_op(t_op[i], t_data[i]);
      bus_rd(REG_STATUS, rd);
      check({30'h0, rd[ST_RDY], rd[ST_BUSY]}, {30'h0, t_mode[i] == 3'd4, 1'b1});
      // address and start writes while busy must not move the running check
      bus_wr(REG_ADDR, 32'h0);
      bus_wr(REG_CTRL, 32'h1);
      bus_rd(REG_ADDR, rd);
      check(rd, 32'h0001_2345);
      bus_rd(REG_CTRL, rd);
      check(rd, {29'h0, t_op[i], 1'b0});
      wait_done;
      check({24'h0, rd[7:0] & t_smask[i]}, {24'h0, t_sexp[i]});
      bus_rd(REG_RDATA, rd);
      check({24'h0, rd[7:0] & t_rmask[i]}, {24'h0, t_rexp[i]});
    end
    check({28'h0, resets}, 32'h2);
    report_and_stop;
  end
endmodule
